// *** src/fidr_regs.svh ***
`ifndef FIDR_REGS_SVH
`define FIDR_REGS_SVH
// ****************************************************************
// Selector codes for the feature ID group
// ****************************************************************
`define FIDR_OPC1 3'h0
`define FIDR_CRN 4'h0
`define FIDR_CRM 4'h1
`define FIDR_OPC2_DEBUG 3'h2
`define FIDR_OPC2_AUX 3'h3
`define FIDR_OPC2_MMF_FIRST 3'h4
`define FIDR_OPC2_MMF_SECOND 3'h5
// ****************************************************************
// Field positions (low bit of each nibble)
// ****************************************************************
`define FIDR_NIB_31_28 28
`define FIDR_NIB_27_24 24
`define FIDR_NIB_23_20 20
`define FIDR_NIB_19_16 16
`define FIDR_NIB_15_12 12
`define FIDR_NIB_11_8 8
`define FIDR_NIB_7_4 4
`define FIDR_NIB_3_0 0
// ****************************************************************
// Field values
// ****************************************************************
`define FIDR_DBG_PERF_MON 4'h2
`define FIDR_DBG_M_PROFILE 4'h0
`define FIDR_DBG_MM_TRACE 4'h1
`define FIDR_DBG_CP_TRACE 4'h0
`define FIDR_DBG_MM_DEBUG 4'h4
`define FIDR_DBG_CP_SEC_DEBUG 4'h4
`define FIDR_DBG_CP_DEBUG 4'h4
`define FIDR_MMF_INNER_SHARE 4'h0
`define FIDR_MMF_FAST_CTX 4'h0
`define FIDR_MMF_AUX_REGS 4'h1
`define FIDR_MMF_TIGHT_MEM 4'h0
`define FIDR_MMF_SHARE_LVLS 4'h0
`define FIDR_MMF_OUTER_SHARE 4'h0
`define FIDR_MMF_PROT_MEM 4'h0
`define FIDR_MMF_VIRT_MEM 4'h3
`define FIDR_MMF2_BRANCH_PRED 4'h4
`define FIDR_MMF2_CACHE 4'h0
`define FIDR_ZERO_WORD 32'h0000_0000
`endif

// *** src/fidr_pkg.sv ***
package fidr_pkg;
  // Access outcome of a read or write request
  typedef enum logic [1:0] {FIDR_IDLE, FIDR_HIT, FIDR_UNDEF} fidr_resp_t;
endpackage

// *** src/fidr_rom.sv ***
`timescale 1ns/1ps
`include "fidr_regs.svh"
// ****************************************************************
// Constant feature word table with registered read data
// ****************************************************************
module fidr_rom
  import fidr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Read port
  input wire logic rd_en,
  input wire logic [2:0] rd_sel,
  output logic [31:0] rd_data
);
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;
  logic [31:0] word;

  // Look up the constant word for a selector
  always_comb begin
    word = `FIDR_ZERO_WORD;
    case (rd_sel)
      `FIDR_OPC2_DEBUG: begin
        word[31:28] = 4'h0;
        word[`FIDR_NIB_27_24 +: 4] = `FIDR_DBG_PERF_MON;
        word[`FIDR_NIB_23_20 +: 4] = `FIDR_DBG_M_PROFILE;
        word[`FIDR_NIB_19_16 +: 4] = `FIDR_DBG_MM_TRACE;
        word[`FIDR_NIB_15_12 +: 4] = `FIDR_DBG_CP_TRACE;
        word[`FIDR_NIB_11_8 +: 4] = `FIDR_DBG_MM_DEBUG;
        word[`FIDR_NIB_7_4 +: 4] = `FIDR_DBG_CP_SEC_DEBUG;
        word[`FIDR_NIB_3_0 +: 4] = `FIDR_DBG_CP_DEBUG;
      end
      `FIDR_OPC2_AUX: begin
        word = `FIDR_ZERO_WORD;
      end
      `FIDR_OPC2_MMF_FIRST: begin
        word[`FIDR_NIB_31_28 +: 4] = `FIDR_MMF_INNER_SHARE;
        word[`FIDR_NIB_27_24 +: 4] = `FIDR_MMF_FAST_CTX;
        word[`FIDR_NIB_23_20 +: 4] = `FIDR_MMF_AUX_REGS;
        word[`FIDR_NIB_19_16 +: 4] = `FIDR_MMF_TIGHT_MEM;
        word[`FIDR_NIB_15_12 +: 4] = `FIDR_MMF_SHARE_LVLS;
        word[`FIDR_NIB_11_8 +: 4] = `FIDR_MMF_OUTER_SHARE;
        word[`FIDR_NIB_7_4 +: 4] = `FIDR_MMF_PROT_MEM;
        word[`FIDR_NIB_3_0 +: 4] = `FIDR_MMF_VIRT_MEM;
      end
      `FIDR_OPC2_MMF_SECOND: begin
        word[`FIDR_NIB_31_28 +: 4] = `FIDR_MMF2_BRANCH_PRED;
        word[27:0] = {7{`FIDR_MMF2_CACHE}};
      end
      default: begin
        word = `FIDR_ZERO_WORD;
      end
    endcase
  end

  // Hold data unless a read is taken
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (rd_en) begin
      rd_data_nxt = word;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= `FIDR_ZERO_WORD;
    end else if (clk_en) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
endmodule

// *** src/fidr_bank.sv ***
`timescale 1ns/1ps
`include "fidr_regs.svh"
module fidr_bank
  import fidr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Coprocessor access
  input wire logic cp_req,
  input wire logic cp_write,
  input wire logic cp_priv,
  input wire logic cp_secure,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  // Response
  output logic cp_ack,
  output logic cp_undef,
  output logic [31:0] cp_rdata
);
  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_r;
  logic rst_n_r;

  // Two-stage release of the reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic grp_hit;
  logic sel_hit;
  logic rd_take;
  logic ack_r;
  logic ack_nxt;
  logic undef_r;
  logic undef_nxt;
  fidr_resp_t resp_nxt;

  // Group and word selection; security state and write data are unused
  always_comb begin
    grp_hit = (cp_opc1 == `FIDR_OPC1) && (cp_crn == `FIDR_CRN)
      && (cp_crm == `FIDR_CRM);
    sel_hit = grp_hit && (cp_opc2 >= `FIDR_OPC2_DEBUG)
      && (cp_opc2 <= `FIDR_OPC2_MMF_SECOND);
    // One shared copy regardless of cp_secure
    rd_take = cp_req && sel_hit && !cp_write && cp_priv;
  end

  // Response classification; writes never reach the table
  always_comb begin
    resp_nxt = FIDR_IDLE;
    if (cp_req) begin
      if (rd_take) begin
        resp_nxt = FIDR_HIT;
      end else if (sel_hit && cp_write && cp_priv) begin
        resp_nxt = FIDR_HIT;
      end else begin
        resp_nxt = FIDR_UNDEF;
      end
    end
    // Decode the outcome into the two response strobes
    ack_nxt = (resp_nxt == FIDR_HIT);
    undef_nxt = (resp_nxt == FIDR_UNDEF);
  end

  // Response strobes, registered so the outputs come from flops
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      undef_r <= 1'b0;
    end else if (clk_en) begin
      ack_r <= ack_nxt;
      undef_r <= undef_nxt;
    end
  end

  // ****************************************************************
  // Constant table
  // ****************************************************************
  logic [31:0] rom_data;

  fidr_rom u_rom (
    .ref_clk(ref_clk),
    .rst_n(rst_n_r),
    .clk_en(clk_en),
    .rd_en(rd_take),
    .rd_sel(cp_opc2),
    .rd_data(rom_data)
  );

  // Outputs straight from flip-flops
  assign cp_ack = ack_r;
  assign cp_undef = undef_r;
  assign cp_rdata = rom_data;

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  // The read data must keep the last fetched word until the next read,
  // so the selector of that read is remembered for the hold check
  logic seen_vld_r;
  logic seen_vld_nxt;
  logic [2:0] seen_sel_r;
  logic [2:0] seen_sel_nxt;
  logic [31:0] seen_word;

  // Remember which word the last accepted read fetched
  always_comb begin
    seen_vld_nxt = seen_vld_r;
    seen_sel_nxt = seen_sel_r;
    if (rd_take) begin
      seen_vld_nxt = 1'b1;
      seen_sel_nxt = cp_opc2;
    end
  end

  // Tracker registers, frozen with the rest of the block
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      seen_vld_r <= 1'b0;
      seen_sel_r <= 3'h0;
    end else if (clk_en) begin
      seen_vld_r <= seen_vld_nxt;
      seen_sel_r <= seen_sel_nxt;
    end
  end

  // Expected word for the remembered selector
  always_comb begin
    case (seen_sel_r)
      `FIDR_OPC2_DEBUG: begin
        seen_word = 32'h0201_0444;
      end
      `FIDR_OPC2_MMF_FIRST: begin
        seen_word = 32'h0010_0003;
      end
      `FIDR_OPC2_MMF_SECOND: begin
        seen_word = 32'h4000_0000;
      end
      default: begin
        seen_word = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  // Word contents one cycle after an accepted read
  dbg_word_a: assert property (clk_en && rd_take && cp_opc2 == `FIDR_OPC2_DEBUG
    |=> cp_rdata == 32'h0201_0444) else $error("debug feature word wrong");
  aux_zero_a: assert property (clk_en && rd_take && cp_opc2 == `FIDR_OPC2_AUX
    |=> cp_rdata == 32'h0000_0000) else $error("aux feature word not zero");
  mmf_first_a: assert property (clk_en && rd_take && cp_opc2 == `FIDR_OPC2_MMF_FIRST
    |=> cp_rdata == 32'h0010_0003) else $error("memory model first word wrong");
  mmf_second_a: assert property (clk_en && rd_take && cp_opc2 == `FIDR_OPC2_MMF_SECOND
    |=> cp_rdata == 32'h4000_0000) else $error("memory model second word wrong");

  // Access decisions
  user_refused_a: assert property (clk_en && cp_req && !cp_priv
    |=> cp_undef && !cp_ack && $stable(cp_rdata)) else $error("user read not refused");
  group_sel_a: assert property (clk_en && cp_req && cp_priv && !cp_write
    && cp_crm != `FIDR_CRM |=> cp_undef) else $error("foreign selector accepted");
  priv_read_a: assert property (clk_en && cp_req && cp_priv && !cp_write && sel_hit
    |=> cp_ack && !cp_undef) else $error("privileged read not accepted");
  priv_write_a: assert property (clk_en && cp_req && cp_priv && cp_write && sel_hit
    |=> cp_ack && !cp_undef) else $error("privileged write not absorbed");
  range_undef_a: assert property (clk_en && cp_req && grp_hit
    && (cp_opc2 < `FIDR_OPC2_DEBUG || cp_opc2 > `FIDR_OPC2_MMF_SECOND) |=> cp_undef && !cp_ack)
    else $error("opcode2 outside the group accepted");
  outer_sel_a: assert property (clk_en && cp_req
    && (cp_opc1 != `FIDR_OPC1 || cp_crn != `FIDR_CRN) |=> cp_undef && !cp_ack)
    else $error("foreign opcode1 or CRn accepted");
  idle_quiet_a: assert property (clk_en && !cp_req |=> !cp_ack && !cp_undef)
    else $error("response without a request");

  // Hold, freeze and security state
  write_kept_a: assert property (clk_en && cp_req && cp_write
    |=> $stable(cp_rdata)) else $error("write changed read data");
  secure_same_a: assert property (clk_en && rd_take ##1 clk_en && rd_take
    && $stable(cp_opc2) && cp_secure != $past(cp_secure) |=> $stable(cp_rdata))
    else $error("secure state changed value");
  rdata_held_a: assert property (seen_vld_r |-> cp_rdata == seen_word)
    else $error("read data lost the last word");
  freeze_hold_a: assert property (!clk_en
    |=> $stable(cp_ack) && $stable(cp_undef) && $stable(cp_rdata))
    else $error("state moved while frozen");
  ack_once_a: assert property (!(cp_ack && cp_undef)) else $error("ack and undef together");

  // Scenarios worth seeing
  dbg_cov_c: cover property (clk_en && rd_take && cp_opc2 == `FIDR_OPC2_DEBUG);
  mmf_cov_c: cover property (clk_en && rd_take && cp_opc2 == `FIDR_OPC2_MMF_SECOND);
  undef_cov_c: cover property (cp_undef);
  wr_cov_c: cover property (clk_en && cp_req && cp_write && sel_hit);
  sec_cov_c: cover property (clk_en && rd_take ##1 clk_en && rd_take
    && cp_secure != $past(cp_secure));
endmodule

// *** test/fidr_bank_tb.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the feature ID bank
// ****************************************************************
module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic cp_req = 1'b0;
  logic cp_write = 1'b0;
  logic cp_priv = 1'b0;
  logic cp_secure = 1'b0;
  logic [2:0] cp_opc1 = 3'h0;
  logic [3:0] cp_crn = 4'h0;
  logic [3:0] cp_crm = 4'h0;
  logic [2:0] cp_opc2 = 3'h0;
  logic [31:0] cp_wdata = 32'h0000_0000;
  logic cp_ack;
  logic cp_undef;
  logic [31:0] cp_rdata;
  logic [31:0] exp_rd = 32'h0000_0000;
  int err_total = 0;
  int n_checks = 0;

  // Clock, 10 ns period
  always #5 ref_clk = ~ref_clk;

  fidr_bank dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .cp_req(cp_req),
    .cp_write(cp_write), .cp_priv(cp_priv), .cp_secure(cp_secure), .cp_opc1(cp_opc1),
    .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_wdata(cp_wdata),
    .cp_ack(cp_ack), .cp_undef(cp_undef), .cp_rdata(cp_rdata));

  // Expected word for each selector value
  function automatic logic [31:0] exp_word(input logic [2:0] o2);
    case (o2)
      3'h2: exp_word = 32'h0201_0444;
      3'h4: exp_word = 32'h0010_0003;
      3'h5: exp_word = 32'h4000_0000;
      default: exp_word = 32'h0000_0000;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One access, presented at a falling edge and judged one cycle later
  task automatic acc(input logic w, input logic p, input logic s, input logic [2:0] o1,
                     input logic [3:0] n, input logic [3:0] m, input logic [2:0] o2);
    logic ok;
    ok = p && o1 == 3'h0 && n == 4'h0 && m == 4'h1 && o2 >= 3'h2 && o2 <= 3'h5;
    cp_req = 1'b1;
    cp_write = w;
    cp_priv = p;
    cp_secure = s;
    cp_opc1 = o1;
    cp_crn = n;
    cp_crm = m;
    cp_opc2 = o2;
    cp_wdata = $urandom;
    @(negedge ref_clk);
    if (ok && !w) exp_rd = exp_word(o2);
    chk({31'h0, cp_ack}, {31'h0, ok}, "ack");
    chk({31'h0, cp_undef}, {31'h0, !ok}, "undef");
    chk(cp_rdata, exp_rd, "rdata");
  endtask

  task automatic idle();
    cp_req = 1'b0;
    @(negedge ref_clk);
    chk({30'h0, cp_ack, cp_undef}, 32'h0000_0000, "idle");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("FAIL t=%0t watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hd81953d6));
    repeat (16) @(negedge ref_clk);
    chk(cp_rdata, 32'h0000_0000, "reset rdata");
    chk({30'h0, cp_ack, cp_undef}, 32'h0000_0000, "reset flags");
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int s = 0; s < 2; s++) begin
      for (int o = 0; o < 8; o++) begin
        acc(1'b0, 1'b1, s[0], 3'h0, 4'h0, 4'h1, o[2:0]);
      end
    end
    $display("test words both states done");
    for (int o = 2; o < 6; o++) begin
      acc(1'b0, 1'b0, 1'b1, 3'h0, 4'h0, 4'h1, o[2:0]);
      acc(1'b1, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, o[2:0]);
      acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, o[2:0]);
      acc(1'b0, 1'b1, 1'b1, 3'h0, 4'h0, 4'h1, o[2:0]);
    end
    acc(1'b0, 1'b1, 1'b0, 3'h1, 4'h0, 4'h1, 3'h4);
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h1, 4'h1, 3'h4);
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h0, 3'h4);
    idle();
    $display("test privilege, writes and selectors done");
    clk_en = 1'b0;
    cp_req = 1'b1;
    @(negedge ref_clk);
    chk({30'h0, cp_ack, cp_undef}, 32'h0000_0000, "frozen");
    chk(cp_rdata, exp_rd, "frozen rdata");
    clk_en = 1'b1;
    idle();
    for (int i = 0; i < 300; i++) begin
      acc(1'($urandom_range(0, 1)), 1'($urandom_range(0, 3) != 0), 1'($urandom_range(0, 1)),
          ($urandom_range(0, 7) == 0) ? 3'($urandom_range(1, 7)) : 3'h0,
          ($urandom_range(0, 7) == 0) ? 4'($urandom_range(1, 15)) : 4'h0,
          ($urandom_range(0, 7) == 0) ? 4'($urandom_range(0, 15)) : 4'h1,
          3'($urandom_range(0, 7)));
    end
    idle();
    $display("test random traffic done");
    reset_n = 1'b0;
    exp_rd = 32'h0000_0000;
    #1;
    chk(cp_rdata, exp_rd, "mid reset rdata");
    chk({30'h0, cp_ack, cp_undef}, 32'h0000_0000, "mid reset flags");
    @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h2);
    idle();
    $display("test second reset done");
    final_report();
  end
endmodule
